// >>> pin_select_map.vh
`ifndef PIN_SELECT_MAP_VH
`define PIN_SELECT_MAP_VH
// Register word offsets on the plain register port
`define ADDR_DTC_IN3_IN2 4'h0
`define ADDR_DTC_IN5_IN4 4'h1
`define ADDR_DTC_IN6 4'h2
`define ADDR_OUT_35_20 4'h3
`define ADDR_OUT_37_36 4'h4
`define ADDR_OUT_39_38 4'h5
`define ADDR_OUT_41_40 4'h6
`define ADDR_OUT_43_42 4'h7
// Field positions
`define IN_HI_LSB 8
`define IN_LO_LSB 0
`define OUT_HI_LSB 8
`define OUT_LO_LSB 0
// Reset value of every select field
`define SEL_RESET 16'h0000
// Input source codes
`define IN_SRC_GROUND 7'h00
`define IN_SRC_COMP1 7'h01
`define IN_SRC_MAX 7'h7c
// Output function code meaning port control
`define OUT_FUNC_PORT 6'h00
`endif

// >>> input_source_mux.v
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_map.vh"
// Routes one of the remappable pins, comparator 1 or ground to one peripheral input
module input_source_mux #(
    parameter PIN_COUNT = 125
) (
    // Clock and reset
    input wire clock_in,
    input wire rst_b_in,
    // Selection and sources
    input wire [6:0] sel_in,
    input wire comparator_one_output_in,
    input wire [PIN_COUNT-1:0] remappable_pin_in,
    // Routed input, registered
    output reg routed_out
);
    reg routed_nxt;

    // Code 0 is ground, code 1 the comparator, codes 2 to 124 the matching pin
    always @* begin
        routed_nxt = 1'b0;
        if (sel_in == `IN_SRC_GROUND) begin
            routed_nxt = 1'b0;
        end else if (sel_in == `IN_SRC_COMP1) begin
            routed_nxt = comparator_one_output_in;
        end else if (sel_in <= `IN_SRC_MAX) begin
            routed_nxt = remappable_pin_in[sel_in];
        end
    end

    // Codes above the last pin read as ground rather than an undefined pin
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            routed_out <= 1'b0;
        end else begin
            routed_out <= routed_nxt;
        end
    end
endmodule // input_source_mux
`default_nettype wire

// >>> remappable_pin_select_deadtime_outputs.v
// What this block does
// - Bits 14-8 of first input register select dead-time compensation input 3.
// - Bits 6-0 of first input register select dead-time compensation input 2.
// - Second input register: input 5 in bits 14-8, input 4 in bits 6-0.
// - Third input register holds only input 6 select; bits 15-7 read zero.
// - Input select code zero drives the peripheral input low.
// - Input select code one routes comparator 1 output.
// - Codes up to 124 route the matching remappable input pin.
// - Output registers read bits 15-14 and 7-6 as zero.
// - Six-bit function fields: pin 35 bits 13-8, pin 20 bits 5-0.
// - Pins 37/36, 39/38, 41/40, 43/42 use the same two-field layout.
// - All select bits are read/write and clear to zero at reset.
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_map.vh"
module remappable_pin_select_deadtime_outputs #(
    parameter PIN_COUNT = 125,
    parameter FUNC_COUNT = 64
) (
    // Clock and reset
    input wire clock_in,
    input wire rst_b_in,
    // Register port
    input wire [3:0] reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire reg_write_in,
    input wire reg_read_in,
    output reg [15:0] reg_rdata_out,
    // Input sources
    input wire comparator_one_output_in,
    input wire [PIN_COUNT-1:0] remappable_pin_in,
    // Dead-time compensation inputs 2 to 6, bit 0 is input 2
    output wire [4:0] deadtime_comp_out,
    // Peripheral outputs and ordinary port drive
    input wire [FUNC_COUNT-1:0] periph_func_in,
    input wire [9:0] port_data_in,
    // Pins 20, 35..43 in that order, bit 0 is pin 20
    output reg [9:0] remappable_pin_out,
    output reg [9:0] pin_func_active_out
);
    // Select fields
    reg [6:0] deadtime_comp2_source_sel;
    reg [6:0] deadtime_comp3_source_sel;
    reg [6:0] deadtime_comp4_source_sel;
    reg [6:0] deadtime_comp5_source_sel;
    reg [6:0] deadtime_comp6_source_sel;
    // Kept as an array so the routing below can loop over the pins
    reg [5:0] out_func_sel_r [0:9];
    reg [15:0] rdata_nxt;
    reg [9:0] pin_nxt;
    reg [9:0] active_nxt;
    integer i;
    integer j;

    // Ten output slots: slot 0 is pin 20, slots 1 to 9 are pins 35 to 43
    localparam OUT_PINS = 10;
    localparam IN_FIELD_W = 7;
    localparam OUT_FIELD_W = 6;

    // Pick a function output; zero means the port owns the pin
    // Six-bit codes 1 to 63 reach default function outputs 1 to 63; output 0 is never routed
    function func_value;
        input [5:0] code;
        input [FUNC_COUNT-1:0] funcs;
        begin
            func_value = funcs[code];
        end
    endfunction

    // Pack two fields in the shared output layout, spare bits zero
    function [15:0] pack_out;
        input [5:0] hi;
        input [5:0] lo;
        begin
            pack_out = {2'b00, hi, 2'b00, lo};
        end
    endfunction

    // Same idea for the input registers: bit 15 and bit 7 are spare
    function [15:0] pack_in;
        input [6:0] hi;
        input [6:0] lo;
        begin
            pack_in = {1'b0, hi, 1'b0, lo};
        end
    endfunction

    // Field pickers keep every register on one decode of the bit positions
    function [6:0] in_hi_field;
        input [15:0] word;
        begin
            in_hi_field = word[`IN_HI_LSB +: IN_FIELD_W];
        end
    endfunction

    function [6:0] in_lo_field;
        input [15:0] word;
        begin
            in_lo_field = word[`IN_LO_LSB +: IN_FIELD_W];
        end
    endfunction

    function [5:0] out_hi_field;
        input [15:0] word;
        begin
            out_hi_field = word[`OUT_HI_LSB +: OUT_FIELD_W];
        end
    endfunction

    function [5:0] out_lo_field;
        input [15:0] word;
        begin
            out_lo_field = word[`OUT_LO_LSB +: OUT_FIELD_W];
        end
    endfunction

    // Input source selects; clearing at reset starts every input grounded
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            deadtime_comp2_source_sel <= 7'h00;
            deadtime_comp3_source_sel <= 7'h00;
            deadtime_comp4_source_sel <= 7'h00;
            deadtime_comp5_source_sel <= 7'h00;
            deadtime_comp6_source_sel <= 7'h00;
        end else if (reg_write_in) begin
            // Codes 125 to 127 are stored as written; the mux treats them as ground
            case (reg_addr_in)
                `ADDR_DTC_IN3_IN2: begin
                    deadtime_comp3_source_sel <= in_hi_field(reg_wdata_in);
                    deadtime_comp2_source_sel <= in_lo_field(reg_wdata_in);
                end
                `ADDR_DTC_IN5_IN4: begin
                    deadtime_comp5_source_sel <= in_hi_field(reg_wdata_in);
                    deadtime_comp4_source_sel <= in_lo_field(reg_wdata_in);
                end
                // Upper byte of this register has no field, so it is dropped
                `ADDR_DTC_IN6: begin
                    deadtime_comp6_source_sel <= in_lo_field(reg_wdata_in);
                end
                default: begin
                end
            endcase
        end
    end

    // Output function selects; zero at reset hands every pin to its port
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (i = 0; i < OUT_PINS; i = i + 1) begin
                out_func_sel_r[i] <= 6'h00;
            end
        end else if (reg_write_in) begin
            // Bits 15-14 and 7-6 of the written word are simply not stored
            case (reg_addr_in)
                `ADDR_OUT_35_20: begin
                    out_func_sel_r[1] <= out_hi_field(reg_wdata_in);
                    out_func_sel_r[0] <= out_lo_field(reg_wdata_in);
                end
                `ADDR_OUT_37_36: begin
                    out_func_sel_r[3] <= out_hi_field(reg_wdata_in);
                    out_func_sel_r[2] <= out_lo_field(reg_wdata_in);
                end
                `ADDR_OUT_39_38: begin
                    out_func_sel_r[5] <= out_hi_field(reg_wdata_in);
                    out_func_sel_r[4] <= out_lo_field(reg_wdata_in);
                end
                `ADDR_OUT_41_40: begin
                    out_func_sel_r[7] <= out_hi_field(reg_wdata_in);
                    out_func_sel_r[6] <= out_lo_field(reg_wdata_in);
                end
                `ADDR_OUT_43_42: begin
                    out_func_sel_r[9] <= out_hi_field(reg_wdata_in);
                    out_func_sel_r[8] <= out_lo_field(reg_wdata_in);
                end
                // Writes to unmapped addresses fall through and change nothing
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always @* begin
        // Default first so no path leaves the word unassigned
        rdata_nxt = 16'h0000;
        // Spare bits come back as zero because the pack functions fill them
        case (reg_addr_in)
            `ADDR_DTC_IN3_IN2: rdata_nxt = pack_in(deadtime_comp3_source_sel,
                                                   deadtime_comp2_source_sel);
            `ADDR_DTC_IN5_IN4: rdata_nxt = pack_in(deadtime_comp5_source_sel,
                                                   deadtime_comp4_source_sel);
            `ADDR_DTC_IN6: rdata_nxt = pack_in(7'h00, deadtime_comp6_source_sel);
            `ADDR_OUT_35_20: rdata_nxt = pack_out(out_func_sel_r[1], out_func_sel_r[0]);
            `ADDR_OUT_37_36: rdata_nxt = pack_out(out_func_sel_r[3], out_func_sel_r[2]);
            `ADDR_OUT_39_38: rdata_nxt = pack_out(out_func_sel_r[5], out_func_sel_r[4]);
            `ADDR_OUT_41_40: rdata_nxt = pack_out(out_func_sel_r[7], out_func_sel_r[6]);
            `ADDR_OUT_43_42: rdata_nxt = pack_out(out_func_sel_r[9], out_func_sel_r[8]);
            default: rdata_nxt = 16'h0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_read_in) begin
            reg_rdata_out <= rdata_nxt;
        end else begin
            // Back to zero, so the word is valid only in the cycle after the strobe
            reg_rdata_out <= 16'h0000;
        end
    end

    // Output routing per pin
    always @* begin
        // Defaults first so every slot is assigned on every path
        pin_nxt = 10'h000;
        active_nxt = 10'h000;
        for (j = 0; j < OUT_PINS; j = j + 1) begin
            if (out_func_sel_r[j] == `OUT_FUNC_PORT) begin
                pin_nxt[j] = port_data_in[j];
            end else begin
                // A nonzero code owns the pin even while that function sits idle
                pin_nxt[j] = func_value(out_func_sel_r[j], periph_func_in);
                active_nxt[j] = 1'b1;
            end
        end
    end

    // Registered pins cost one cycle of latency but keep outputs glitch free
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            remappable_pin_out <= 10'h000;
            pin_func_active_out <= 10'h000;
        end else begin
            // Level and flag share one stage, so they never disagree for a cycle
            remappable_pin_out <= pin_nxt;
            pin_func_active_out <= active_nxt;
        end
    end

    // One routing mux per compensation input
    // Each mux registers its result, so a select change shows one cycle later
    // Input 2 lands on bit 0
    input_source_mux #(
        .PIN_COUNT(PIN_COUNT)
    ) u_mux2 (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .sel_in(deadtime_comp2_source_sel),
        .comparator_one_output_in(comparator_one_output_in),
        .remappable_pin_in(remappable_pin_in),
        .routed_out(deadtime_comp_out[0])
    );

    // Input 3 lands on bit 1
    input_source_mux #(
        .PIN_COUNT(PIN_COUNT)
    ) u_mux3 (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .sel_in(deadtime_comp3_source_sel),
        .comparator_one_output_in(comparator_one_output_in),
        .remappable_pin_in(remappable_pin_in),
        .routed_out(deadtime_comp_out[1])
    );

    // Input 4 lands on bit 2
    input_source_mux #(
        .PIN_COUNT(PIN_COUNT)
    ) u_mux4 (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .sel_in(deadtime_comp4_source_sel),
        .comparator_one_output_in(comparator_one_output_in),
        .remappable_pin_in(remappable_pin_in),
        .routed_out(deadtime_comp_out[2])
    );

    // Input 5 lands on bit 3
    input_source_mux #(
        .PIN_COUNT(PIN_COUNT)
    ) u_mux5 (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .sel_in(deadtime_comp5_source_sel),
        .comparator_one_output_in(comparator_one_output_in),
        .remappable_pin_in(remappable_pin_in),
        .routed_out(deadtime_comp_out[3])
    );

    // Input 6 lands on bit 4
    input_source_mux #(
        .PIN_COUNT(PIN_COUNT)
    ) u_mux6 (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .sel_in(deadtime_comp6_source_sel),
        .comparator_one_output_in(comparator_one_output_in),
        .remappable_pin_in(remappable_pin_in),
        .routed_out(deadtime_comp_out[4])
    );
endmodule // remappable_pin_select_deadtime_outputs
`default_nettype wire

// >>> pin_select_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pin_select_checker #(parameter PIN_COUNT = 125, parameter FUNC_COUNT = 64) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic comparator_one_output_in,
    input wire logic [PIN_COUNT-1:0] remappable_pin_in,
    input wire logic [4:0] deadtime_comp_out,
    input wire logic [FUNC_COUNT-1:0] periph_func_in,
    input wire logic [9:0] port_data_in,
    input wire logic [9:0] remappable_pin_out,
    input wire logic [9:0] pin_func_active_out
);
    logic [15:0] sh [0:7];
    logic [15:0] x_rd;
    logic [6:0] s;
    logic [5:0] c;
    logic [4:0] x_dt;
    logic [9:0] x_pin;
    logic [9:0] x_act;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);
    // Shadow of the fields, cut to implemented bits so reads can be predicted
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < 8; i++)
                sh[i] <= 16'h0000;
        end else if (reg_write_in && !reg_addr_in[3]) begin
            sh[reg_addr_in[2:0]] <= reg_wdata_in & (reg_addr_in < 4'h2 ? 16'h7f7f :
                reg_addr_in == 4'h2 ? 16'h007f : 16'h3f3f);
        end
    end
    // Expected routing; codes past 124 fall back to ground
    always_comb begin
        x_rd = reg_addr_in[3] ? 16'h0000 : sh[reg_addr_in[2:0]];
        for (int i = 0; i < 5; i++) begin
            s = sh[i / 2][(i % 2) * 8 +: 7];
            x_dt[i] = s == 7'h01 ? comparator_one_output_in :
                (s > 7'h01 && s <= 7'h7c) ? remappable_pin_in[s] : 1'b0;
        end
        for (int j = 0; j < 10; j++) begin
            c = sh[3 + j / 2][(j % 2) * 8 +: 6];
            x_act[j] = c != 6'h00;
            x_pin[j] = x_act[j] ? periph_func_in[c] : port_data_in[j];
        end
    end
    chk_read_value: assert property (reg_read_in |=> reg_rdata_out == $past(x_rd))
        else $error("read data wrong");
    chk_read_idle: assert property (!reg_read_in |=> reg_rdata_out == 16'h0000)
        else $error("read data not idle");
    chk_write_read: assert property (reg_write_in && !reg_addr_in[3] ##1 reg_read_in &&
        reg_addr_in == $past(reg_addr_in) |=> reg_rdata_out[5:0] == 6'($past(reg_wdata_in, 2)))
        else $error("written field not read back");
    chk_dt_route: assert property (deadtime_comp_out == $past(x_dt))
        else $error("dead-time input wrongly routed");
    chk_comp_route: assert property ($past(sh[0][6:0] == 7'h01) |->
        deadtime_comp_out[0] == $past(comparator_one_output_in)) else $error("comparator not routed");
    chk_in6_ground: assert property ((sh[2][6:0] == 7'h00) [*2] |-> !deadtime_comp_out[4])
        else $error("grounded input not low");
    chk_pin_route: assert property ($past(rst_b_in) |-> remappable_pin_out == $past(x_pin))
        else $error("output pin wrongly driven");
    chk_pin_active: assert property (pin_func_active_out == $past(x_act))
        else $error("function flag wrong");
    cover property (reg_read_in && reg_addr_in == 4'h7);
    cover property (sh[0][6:0] == 7'h01 && comparator_one_output_in);
    cover property (pin_func_active_out[9]);
endmodule // pin_select_checker
bind remappable_pin_select_deadtime_outputs pin_select_checker #(.PIN_COUNT(PIN_COUNT),
    .FUNC_COUNT(FUNC_COUNT)) chk (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .comparator_one_output_in(comparator_one_output_in), .remappable_pin_in(remappable_pin_in),
    .deadtime_comp_out(deadtime_comp_out), .periph_func_in(periph_func_in),
    .port_data_in(port_data_in), .remappable_pin_out(remappable_pin_out),
    .pin_func_active_out(pin_func_active_out));
`default_nettype wire

// >>> remappable_pin_select_deadtime_outputs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module remappable_pin_select_deadtime_outputs_tb_top;
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic comp = 1'b0;
    logic [124:0] pins = 125'h0;
    logic [63:0] funcs = 64'h0;
    logic [9:0] port = 10'h000;
    wire logic [15:0] rdata;
    wire logic [4:0] dt;
    wire logic [9:0] pin_out;
    wire logic [9:0] act;
    int mismatches = 0;
    int n_checks = 0;
    int k;
    logic e;
    logic [6:0] c_in [8] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h39, 7'h7c, 7'h7d, 7'h7f};
    logic [5:0] c_out [4] = '{6'h00, 6'h01, 6'h21, 6'h3f};
    remappable_pin_select_deadtime_outputs dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
        .reg_read_in(reg_read_in), .reg_rdata_out(rdata), .comparator_one_output_in(comp),
        .remappable_pin_in(pins), .deadtime_comp_out(dt), .periph_func_in(funcs),
        .port_data_in(port), .remappable_pin_out(pin_out), .pin_func_active_out(act));
    // Free-running clock, 50 ns period
    always #25 clock_in = ~clock_in;
    task automatic check(input logic [15:0] seen, input logic [15:0] x);
        n_checks++;
        if (seen !== x) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, x);
        end
    endtask
    // Write strobe is left high so writes may run back to back
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_read_in <= 1'b0;
        reg_write_in <= 1'b1;
        @(posedge clock_in);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] x);
        reg_addr_in <= a;
        reg_write_in <= 1'b0;
        reg_read_in <= 1'b1;
        @(posedge clock_in);
        reg_read_in <= 1'b0;
        @(negedge clock_in);
        check(rdata, x);
        @(posedge clock_in);
    endtask
    task automatic idle(input int n);
        reg_write_in <= 1'b0;
        repeat (n) @(posedge clock_in);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watchdog, far beyond the expected run of about 575 cycles
    initial begin
        #1000000;
        mismatches++;
        stop_test();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clock_in);
        rst_b_in <= 1'b1;
        @(posedge clock_in);
        for (int a = 0; a < 16; a++)
            rd(4'(a), 16'h0000);
        $display("reset values done");
        for (int a = 0; a < 16; a++) begin
            wr(4'(a), 16'hffff);
            rd(4'(a), a > 7 ? 16'h0000 : a == 2 ? 16'h007f : a < 2 ? 16'h7f7f : 16'h3f3f);
        end
        $display("field masks done");
        for (int p = 0; p < 2; p++) begin
            comp <= p[0];
            for (int n = 0; n < 125; n++)
                pins[n] <= n[0] ^ n[2] ^ p[0];
            for (int i = 0; i < 5; i++) begin
                for (int c = 0; c < 8; c++) begin
                    wr(4'(i / 2), 16'(c_in[c]) << (8 * (i % 2)));
                    idle(2);
                    k = c_in[c];
                    e = (k == 0 || k > 124) ? 1'b0 : k == 1 ? p[0] : pins[k];
                    check(16'(dt[i]), 16'(e));
                end
            end
        end
        $display("input routing done");
        for (int p = 0; p < 2; p++) begin
            funcs <= p[0] ? 64'h5a3c_0f96_a5c3_f069 : 64'ha5c3_f069_5a3c_0f96;
            port <= p[0] ? 10'h14a : 10'h2b5;
            for (int j = 0; j < 10; j++) begin
                for (int c = 0; c < 4; c++) begin
                    wr(4'(3 + j / 2), 16'(c_out[c]) << (8 * (j % 2)));
                    idle(2);
                    e = c_out[c] == 6'h00 ? port[j] : funcs[c_out[c]];
                    check(16'(pin_out[j]), 16'(e));
                    check(16'(act[j]), 16'(c_out[c] != 6'h00));
                end
            end
        end
        $display("output routing done");
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        rst_b_in <= 1'b1;
        @(posedge clock_in);
        rd(4'h7, 16'h0000);
        $display("second reset done");
        stop_test();
    end
endmodule // remappable_pin_select_deadtime_outputs_tb_top
`default_nettype wire
